// ### core/cbbie_alu.sv
// Compare, shift, swap and bit-transfer datapath
`timescale 1ns/10ps
module cbbie_alu
  import cbbie_pkg::*;
(
  // Operation and operands
  input  cbbie_op_t  op,
  input  logic [7:0] opd_a,
  input  logic [7:0] opd_b,
  input  logic [2:0] bit_sel,
  input  logic [7:0] sts_in,
  // Results
  output logic [7:0] res,
  output logic [7:0] sts_out
);

  logic [8:0] diff;
  logic       cin;
  logic       n_f;
  logic       c_f;
  logic       v_f;

  always_comb
  begin
    res     = opd_a;
    sts_out = sts_in;
    cin     = (op == OP_COMPARE_WITH_CARRY) ? sts_in[SB_C] : 1'b0;
    diff    = {1'b0, opd_a} - {1'b0, opd_b} - {8'h00, cin};
    n_f     = 1'b0;
    c_f     = 1'b0;
    v_f     = 1'b0;
    unique case (op)
      OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE:
      begin
        n_f = diff[7];
        c_f = diff[8];
        v_f = (opd_a[7] & ~opd_b[7] & ~diff[7])
            | (~opd_a[7] & opd_b[7] & diff[7]);
        sts_out[SB_Z] = (diff[7:0] == 8'h00) &
          ((op == OP_COMPARE_WITH_CARRY) ? sts_in[SB_Z] : 1'b1);
        sts_out[SB_C] = c_f;
        sts_out[SB_N] = n_f;
        sts_out[SB_V] = v_f;
        sts_out[SB_S] = n_f ^ v_f;
        sts_out[SB_H] = (~opd_a[3] & opd_b[3]) | (opd_b[3] & diff[3])
                      | (diff[3] & ~opd_a[3]);
      end
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH:
      begin
        unique case (op)
          OP_SHIFT_LEFT_LOGICAL:
          begin
            res = {opd_a[6:0], 1'b0};
            c_f = opd_a[7];
          end
          OP_SHIFT_RIGHT_LOGICAL:
          begin
            res = {1'b0, opd_a[7:1]};
            c_f = opd_a[0];
          end
          OP_ROTATE_LEFT_CARRY:
          begin
            res = {opd_a[6:0], sts_in[SB_C]};
            c_f = opd_a[7];
          end
          OP_ROTATE_RIGHT_CARRY:
          begin
            res = {sts_in[SB_C], opd_a[7:1]};
            c_f = opd_a[0];
          end
          default:
          begin
            res = {opd_a[7], opd_a[7:1]};
            c_f = opd_a[0];
          end
        endcase
        n_f = res[7];
        v_f = n_f ^ c_f;
        sts_out[SB_Z] = (res == 8'h00);
        sts_out[SB_C] = c_f;
        sts_out[SB_N] = n_f;
        sts_out[SB_V] = v_f;
        sts_out[SB_S] = n_f ^ v_f;
      end
      OP_NIBBLE_SWAP:
        res = {opd_a[NIB_LO_MSB:0], opd_a[NIB_HI_MSB:NIB_LO_MSB+3'h1]};
      OP_BIT_TO_TRANSFER_FLAG:
        sts_out[SB_T] = opd_a[bit_sel];
      OP_TRANSFER_FLAG_TO_BIT:
        res[bit_sel] = sts_in[SB_T];
      default:
      begin
        res     = opd_a;
        sts_out = sts_in;
      end
    endcase
  end

endmodule : cbbie_alu

// ### core/cbbie_core.sv
// Execution sequencer for branch, skip, bit and shift instructions
`timescale 1ns/10ps
module cbbie_core
  import cbbie_pkg::*;
#(
  parameter int          PC_W   = 10,
  parameter int          OFS_W  = 12,
  parameter logic [9:0]  PC_RST = 10'h000
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Decoded instruction
  input  wire logic              instr_valid,
  input  wire cbbie_op_t         instr_op,
  input  wire logic [7:0]        opd_a,
  input  wire logic [7:0]        opd_b,
  input  wire logic [2:0]        bit_sel,
  input  wire logic [2:0]        flag_sel,
  input  wire logic [OFS_W-1:0]  ofs_k,
  input  wire logic              next_two_word,
  output logic                   instr_ready,
  // I/O space and stack
  input  wire logic [7:0]        io_rd_data,
  input  wire logic [PC_W-1:0]   stack_pc,
  // Program counter and status
  output logic [PC_W-1:0]        pc_q,
  output logic [7:0]             status_q,
  // Register and I/O writes
  output logic                   rd_we_q,
  output logic [7:0]             rd_wdata_q,
  output logic                   io_we_q,
  output logic [7:0]             io_wdata_q,
  // Side effects
  output logic                   push_q,
  output logic [PC_W-1:0]        push_pc_q,
  output logic                   pop_q,
  output logic                   mem_rd_q,
  output logic                   mem_wr_q,
  output logic                   pmem_rd_q,
  output logic                   sleep_q,
  output logic                   wdt_restart_q
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc,
                                             input logic [OFS_W-1:0] k);
    logic [31:0] ext;
    logic [31:0] sum;
    ext = {{(32-OFS_W){k[OFS_W-1]}}, k};
    sum = {{(32-PC_W){1'b0}}, pc} + ext + 32'h1;
    return sum[PC_W-1:0];
  endfunction : pc_rel

  function automatic logic branch_cond(input cbbie_op_t op,
                                       input logic [7:0] s,
                                       input logic [2:0] sel);
    logic r;
    r = 1'b0;
    unique case (op)
      OP_BRANCH_STATUS_BIT_SET:   r = s[sel];
      OP_BRANCH_STATUS_BIT_CLEAR: r = ~s[sel];
      OP_BRANCH_EQUAL:            r = s[SB_Z];
      OP_BRANCH_NOT_EQUAL:        r = ~s[SB_Z];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:            r = s[SB_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER:      r = ~s[SB_C];
      OP_BRANCH_MINUS:            r = s[SB_N];
      OP_BRANCH_PLUS:             r = ~s[SB_N];
      OP_BRANCH_SIGNED_GE:        r = ~(s[SB_N] ^ s[SB_V]);
      OP_BRANCH_SIGNED_LT:        r = s[SB_N] ^ s[SB_V];
      OP_BRANCH_HALF_SET:         r = s[SB_H];
      OP_BRANCH_HALF_CLEAR:       r = ~s[SB_H];
      OP_BRANCH_TFLAG_SET:        r = s[SB_T];
      OP_BRANCH_TFLAG_CLEAR:      r = ~s[SB_T];
      OP_BRANCH_OVF_SET:          r = s[SB_V];
      OP_BRANCH_OVF_CLEAR:        r = ~s[SB_V];
      OP_BRANCH_INT_SET:          r = s[SB_I];
      OP_BRANCH_INT_CLEAR:        r = ~s[SB_I];
      default:                    r = 1'b0;
    endcase
    return r;
  endfunction : branch_cond

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic [7:0]      alu_res;
  logic [7:0]      alu_sts;
  logic [2:0]      busy_q;
  logic [2:0]      busy_d;
  logic [PC_W-1:0] pc_d;
  logic [7:0]      status_d;
  logic            rd_we_d;
  logic [7:0]      rd_wdata_d;
  logic            io_we_d;
  logic [7:0]      io_wdata_d;
  logic            push_d;
  logic [PC_W-1:0] push_pc_d;
  logic            pop_d;
  logic            mem_rd_d;
  logic            mem_wr_d;
  logic            pmem_rd_d;
  logic            sleep_d;
  logic            wdt_restart_d;
  logic            accept;
  logic            skip;
  logic [2:0]      cyc;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_skip;

  cbbie_alu u_alu (
    .op      (instr_op),
    .opd_a   (opd_a),
    .opd_b   (opd_b),
    .bit_sel (bit_sel),
    .sts_in  (status_q),
    .res     (alu_res),
    .sts_out (alu_sts)
  );

  assign instr_ready = (busy_q == 3'h0);
  assign accept      = instr_valid & instr_ready;
  assign pc_inc      = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  assign pc_skip     = pc_inc + {{(PC_W-1){1'b0}}, 1'b1}
                     + {{(PC_W-1){1'b0}}, next_two_word};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    pc_d          = pc_q;
    status_d      = status_q;
    busy_d        = (busy_q == 3'h0) ? 3'h0 : busy_q - 3'h1;
    rd_we_d       = 1'b0;
    rd_wdata_d    = rd_wdata_q;
    io_we_d       = 1'b0;
    io_wdata_d    = io_wdata_q;
    push_d        = 1'b0;
    push_pc_d     = push_pc_q;
    pop_d         = 1'b0;
    mem_rd_d      = 1'b0;
    mem_wr_d      = 1'b0;
    pmem_rd_d     = 1'b0;
    sleep_d       = 1'b0;
    wdt_restart_d = 1'b0;
    skip          = 1'b0;
    cyc           = CYC_ONE;
    if (accept)
    begin
      pc_d = pc_inc;
      unique case (instr_op)
        OP_COMPARE_SKIP_EQUAL:  skip = (opd_a == opd_b);
        OP_SKIP_REG_BIT_CLEAR:  skip = ~opd_a[bit_sel];
        OP_SKIP_REG_BIT_SET:    skip = opd_a[bit_sel];
        OP_SKIP_IO_BIT_CLEAR:   skip = ~io_rd_data[bit_sel];
        OP_SKIP_IO_BIT_SET:     skip = io_rd_data[bit_sel];
        OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE:
          status_d = alu_sts;
        OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
        OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_LOWER, OP_BRANCH_SAME_HIGHER,
        OP_BRANCH_MINUS, OP_BRANCH_PLUS,
        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_SET, OP_BRANCH_HALF_CLEAR,
        OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR,
        OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR,
        OP_BRANCH_INT_SET, OP_BRANCH_INT_CLEAR:
        begin
          if (branch_cond(instr_op, status_q, flag_sel))
          begin
            pc_d = pc_rel(pc_q, ofs_k);
            cyc  = CYC_TWO;
          end
        end
        OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP:
        begin
          io_we_d             = 1'b1;
          io_wdata_d          = io_rd_data;
          io_wdata_d[bit_sel] = (instr_op == OP_IO_BIT_SET_OP);
          cyc                 = CYC_TWO;
        end
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH:
        begin
          rd_we_d    = 1'b1;
          rd_wdata_d = alu_res;
          status_d   = alu_sts;
        end
        OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT:
        begin
          rd_we_d    = 1'b1;
          rd_wdata_d = alu_res;
        end
        OP_BIT_TO_TRANSFER_FLAG:  status_d = alu_sts;
        OP_FLAG_SET:              status_d[flag_sel] = 1'b1;
        OP_FLAG_CLEAR:            status_d[flag_sel] = 1'b0;
        OP_SLEEP:                 sleep_d = 1'b1;
        OP_WATCHDOG_RESTART:      wdt_restart_d = 1'b1;
        OP_NOP:                   cyc = CYC_ONE;
        OP_RELATIVE_JUMP:
        begin
          pc_d = pc_rel(pc_q, ofs_k);
          cyc  = CYC_TWO;
        end
        OP_RELATIVE_CALL:
        begin
          pc_d      = pc_rel(pc_q, ofs_k);
          push_d    = 1'b1;
          push_pc_d = pc_inc;
          cyc       = CYC_THREE;
        end
        OP_RETURN, OP_INTERRUPT_RETURN:
        begin
          pc_d  = stack_pc;
          pop_d = 1'b1;
          cyc   = CYC_FOUR;
          if (instr_op == OP_INTERRUPT_RETURN)
            status_d[SB_I] = 1'b1;
        end
        OP_LOAD_INDIRECT:
        begin
          mem_rd_d = 1'b1;
          cyc      = CYC_TWO;
        end
        OP_STORE_INDIRECT:
        begin
          mem_wr_d = 1'b1;
          cyc      = CYC_TWO;
        end
        OP_PROGRAM_MEMORY_LOAD:
        begin
          pmem_rd_d = 1'b1;
          cyc       = CYC_THREE;
        end
        OP_MOVE, OP_LOAD_IMMEDIATE:
        begin
          rd_we_d    = 1'b1;
          rd_wdata_d = opd_b;
        end
        OP_IO_IN:
        begin
          rd_we_d    = 1'b1;
          rd_wdata_d = io_rd_data;
        end
        OP_IO_OUT:
        begin
          io_we_d    = 1'b1;
          io_wdata_d = opd_a;
        end
      endcase
      if (skip)
      begin
        pc_d = pc_skip;
        cyc  = CYC_TWO;
      end
      busy_d = cyc - CYC_ONE;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q          <= PC_RST[PC_W-1:0];
      status_q      <= STATUS_RST;
      busy_q        <= 3'h0;
      rd_we_q       <= 1'b0;
      rd_wdata_q    <= 8'h00;
      io_we_q       <= 1'b0;
      io_wdata_q    <= 8'h00;
      push_q        <= 1'b0;
      push_pc_q     <= '0;
      pop_q         <= 1'b0;
      mem_rd_q      <= 1'b0;
      mem_wr_q      <= 1'b0;
      pmem_rd_q     <= 1'b0;
      sleep_q       <= 1'b0;
      wdt_restart_q <= 1'b0;
    end
    else
    begin
      pc_q          <= pc_d;
      status_q      <= status_d;
      busy_q        <= busy_d;
      rd_we_q       <= rd_we_d;
      rd_wdata_q    <= rd_wdata_d;
      io_we_q       <= io_we_d;
      io_wdata_q    <= io_wdata_d;
      push_q        <= push_d;
      push_pc_q     <= push_pc_d;
      pop_q         <= pop_d;
      mem_rd_q      <= mem_rd_d;
      mem_wr_q      <= mem_wr_d;
      pmem_rd_q     <= pmem_rd_d;
      sleep_q       <= sleep_d;
      wdt_restart_q <= wdt_restart_d;
    end
  end

endmodule : cbbie_core

// ### dv/cbbie_core_props.sv
// Concurrent checks on the ports of the execution sequencer
`timescale 1ns/10ps
module cbbie_core_props
  import cbbie_pkg::*;
#(
  parameter int PC_W  = 10,
  parameter int OFS_W = 12
)
(
  // Clock and reset
  input logic             core_clk,
  input logic             rst_n,
  // Instruction side
  input logic             instr_valid,
  input cbbie_op_t        instr_op,
  input logic [7:0]       opd_a,
  input logic [2:0]       bit_sel,
  input logic [2:0]       flag_sel,
  input logic [OFS_W-1:0] ofs_k,
  input logic             next_two_word,
  input logic             instr_ready,
  input logic [7:0]       io_rd_data,
  input logic [PC_W-1:0]  stack_pc,
  // Results
  input logic [PC_W-1:0]  pc_q,
  input logic [7:0]       status_q,
  input logic             rd_we_q,
  input logic [7:0]       rd_wdata_q,
  input logic             io_we_q,
  input logic [7:0]       io_wdata_q,
  input logic             push_q,
  input logic [PC_W-1:0]  push_pc_q,
  input logic             pop_q,
  input logic             sleep_q
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic tk;
  assign tk = instr_valid & instr_ready;

  chk_jump_stall: assert property (
    tk && instr_op == OP_RELATIVE_JUMP |=> !instr_ready ##1 instr_ready)
    else $error("relative jump stall wrong");
  chk_call_push: assert property (
    tk && instr_op == OP_RELATIVE_CALL |=> push_q &&
    push_pc_q == PC_W'($past(pc_q) + 1) ##0 !instr_ready [*2] ##1 instr_ready)
    else $error("relative call wrong");
  chk_return_pop: assert property (
    tk && instr_op inside {OP_RETURN, OP_INTERRUPT_RETURN} |=> pop_q &&
    pc_q == $past(stack_pc) ##0 !instr_ready [*3] ##1 instr_ready)
    else $error("return wrong");
  chk_interrupt_return_sets_i: assert property (
    tk && instr_op == OP_INTERRUPT_RETURN |=> status_q[SB_I])
    else $error("interrupt return left I clear");
  chk_io_bit_set: assert property (
    tk && instr_op == OP_IO_BIT_SET_OP |=> io_we_q && $stable(status_q) &&
    io_wdata_q == ($past(io_rd_data) | (8'h01 << $past(bit_sel))))
    else $error("io bit set wrong");
  chk_nibble_swap: assert property (
    tk && instr_op == OP_NIBBLE_SWAP |=> rd_we_q && $stable(status_q) &&
    rd_wdata_q == (($past(opd_a) << 4) | ($past(opd_a) >> 4)))
    else $error("nibble swap wrong");
  chk_branch_eq: assert property (
    tk && instr_op == OP_BRANCH_EQUAL && status_q[SB_Z] |=>
    pc_q == PC_W'($past(pc_q) + $past(ofs_k) + 1) ##0 !instr_ready)
    else $error("taken branch wrong");
  chk_lt_not_taken: assert property (
    tk && instr_op == OP_BRANCH_SIGNED_LT && status_q[SB_N] == status_q[SB_V]
    |=> instr_ready && pc_q == PC_W'($past(pc_q) + 1))
    else $error("signed branch wrong");
  chk_flag_set: assert property (
    tk && instr_op == OP_FLAG_SET |=>
    status_q == ($past(status_q) | (8'h01 << $past(flag_sel))))
    else $error("flag set wrong");
  chk_skip_set: assert property (
    tk && instr_op == OP_SKIP_REG_BIT_SET && opd_a[bit_sel] |=>
    pc_q == PC_W'($past(pc_q) + ($past(next_two_word) ? 3 : 2)) ##0 !instr_ready)
    else $error("register bit skip wrong");
  chk_sleep_pulse: assert property (
    tk && instr_op == OP_SLEEP |=> sleep_q ##1 !sleep_q)
    else $error("sleep pulse wrong");
  chk_stall_holds: assert property (
    !instr_ready |=> $stable(pc_q) && $stable(status_q))
    else $error("state changed during stall");
endmodule : cbbie_core_props

// ### dv/cbbie_core_tb.sv
// Self-checking bench of the execution sequencer
`timescale 1ns/10ps
module cbbie_core_tb import cbbie_pkg::*;;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [8:0] P_RD = 9'h100, P_IO = 9'h080, P_PU = 9'h040;
  localparam logic [8:0] P_PO = 9'h020, P_MR = 9'h010, P_MW = 9'h008;
  localparam logic [8:0] P_PM = 9'h004, P_SL = 9'h002, P_WD = 9'h001;
  int         errors, comparisons;
  cbbie_op_t  instr_op;
  logic       core_clk, rst_n, instr_valid, next_two_word, instr_ready;
  logic       rd_we_q, io_we_q, push_q, pop_q, mem_rd_q, mem_wr_q;
  logic       pmem_rd_q, sleep_q, wdt_restart_q;
  logic [7:0] opd_a, opd_b, io_rd_data, status_q, rd_wdata_q, io_wdata_q;
  logic [2:0] bit_sel, flag_sel;
  logic [11:0] ofs_k;
  logic [9:0] stack_pc, pc_q, push_pc_q, pc_s;
  cbbie_core dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_op(instr_op), .opd_a(opd_a),
    .opd_b(opd_b), .bit_sel(bit_sel), .flag_sel(flag_sel), .ofs_k(ofs_k),
    .next_two_word(next_two_word), .instr_ready(instr_ready),
    .io_rd_data(io_rd_data), .stack_pc(stack_pc), .pc_q(pc_q),
    .status_q(status_q), .rd_we_q(rd_we_q), .rd_wdata_q(rd_wdata_q),
    .io_we_q(io_we_q), .io_wdata_q(io_wdata_q), .push_q(push_q),
    .push_pc_q(push_pc_q), .pop_q(pop_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .pmem_rd_q(pmem_rd_q), .sleep_q(sleep_q),
    .wdt_restart_q(wdt_restart_q));
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic run(cbbie_op_t op, logic [7:0] a, b, logic [2:0] bs,
    logic [11:0] k, logic tw, int cyc, logic [9:0] dp, logic [7:0] es,
    logic [8:0] ep);
    logic [9:0] p0;
    p0 = pc_q;
    instr_op = op;
    opd_a = a;
    opd_b = b;
    bit_sel = bs;
    flag_sel = bs;
    ofs_k = k;
    next_two_word = tw;
    instr_valid = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("pulses", {rd_we_q, io_we_q, push_q, pop_q, mem_rd_q, mem_wr_q,
      pmem_rd_q, sleep_q, wdt_restart_q}, ep);
    repeat (cyc - 1)
    begin
      chk("stall", instr_ready, 1'b0);
      @(negedge core_clk);
    end
    chk("ready", instr_ready, 1'b1);
    chk("pc", pc_q, 10'(p0 + dp));
    chk("status", status_q, es);
  endtask : run
  task automatic set_st(logic [7:0] v);
    logic [7:0] e;
    e = status_q;
    for (int i = 0; i < 8; i++)
    begin
      e[i] = v[i];
      run(v[i] ? OP_FLAG_SET : OP_FLAG_CLEAR, 8'h00, 8'h00, 3'(i), 12'h000,
        1'b0, 1, 10'h001, e, 9'h000);
    end
  endtask : set_st
  task automatic brn(logic [7:0] v);
    logic [2:0] f;
    logic x, t;
    logic [11:0] k;
    set_st(v);
    for (int j = 0; j < 20; j++)
    begin
      case (j)
        0, 1: f = 3'(j);
        2, 3: f = SB_Z;
        8, 9: f = SB_N;
        12, 13: f = SB_H;
        14, 15: f = SB_T;
        16, 17: f = SB_V;
        18, 19: f = SB_I;
        default: f = SB_C;
      endcase
      x = (j == 10 || j == 11) ? ~(v[SB_N] ^ v[SB_V]) : v[f];
      t = (x == ~j[0]);
      k = j[0] ? 12'hffd : 12'h005;
      run(cbbie_op_t'(int'(OP_BRANCH_STATUS_BIT_SET) + j), 8'h00, 8'h00, f,
        k, 1'b0, t ? 2 : 1, t ? k[9:0] + 10'h001 : 10'h001, v,
        9'h000);
    end
  endtask : brn
  task automatic shf(cbbie_op_t op, logic [7:0] a, logic [2:0] bs,
    logic [7:0] ew, es);
    run(op, a, 8'h00, bs, 12'h000, 1'b0, 1, 10'h001, es, P_RD);
    chk("wdata", rd_wdata_q, ew);
  endtask : shf
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    #20us;
    errors++;
    summarize();
  end
  initial
  begin
    {core_clk, rst_n, instr_valid, next_two_word} = 4'h0;
    instr_op = OP_NOP;
    {opd_a, opd_b, io_rd_data, bit_sel, flag_sel} = 30'h0;
    ofs_k = 12'h000;
    stack_pc = 10'h155;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset pc", pc_q, 10'h000);
    chk("reset status", status_q, 8'h00);
    $display("reset test done");
    set_st(8'hff);
    set_st(8'h00);
    $display("flag test done");
    brn(8'h55);
    brn(8'haa);
    brn(8'h0f);
    $display("branch test done");
    for (int o = 0; o < 4; o++)
      for (int b = 3; b < 5; b++)
      begin
        io_rd_data = o[1] ? 8'h08 : 8'hf7;
        run(cbbie_op_t'(int'(OP_SKIP_REG_BIT_CLEAR) + o),
          o[1] ? 8'hf7 : 8'h08, 8'h00, 3'(b), 12'h000, b == 4,
          ((b == 3) == o[0]) ? 2 : 1, ((b == 3) == o[0]) ?
          ((b == 4) ? 10'h003 : 10'h002) : 10'h001, status_q,
          9'h000);
      end
    run(OP_COMPARE_SKIP_EQUAL, 8'h3c, 8'h3c, 3'h0, 12'h000, 1'b1, 2,
      10'h003, status_q, 9'h000);
    run(OP_COMPARE_SKIP_EQUAL, 8'h3c, 8'h3d, 3'h0, 12'h000, 1'b0, 1,
      10'h001, status_q, 9'h000);
    $display("skip test done");
    set_st(8'hc0);
    run(OP_COMPARE, 8'h10, 8'h20, 3'h0, 12'h000, 1'b0, 1, 10'h001, 8'hd5,
      9'h000);
    run(OP_COMPARE_WITH_CARRY, 8'h20, 8'h1f, 3'h0, 12'h000, 1'b0, 1,
      10'h001, 8'he0, 9'h000);
    run(OP_COMPARE_IMMEDIATE, 8'h20, 8'h20, 3'h0, 12'h000, 1'b0, 1,
      10'h001, 8'hc2, 9'h000);
    run(OP_COMPARE_WITH_CARRY, 8'h20, 8'h20, 3'h0, 12'h000, 1'b0, 1,
      10'h001, 8'hc2, 9'h000);
    $display("compare test done");
    set_st(8'h01);
    shf(OP_SHIFT_LEFT_LOGICAL, 8'h81, 3'h0, 8'h02, 8'h19);
    shf(OP_SHIFT_RIGHT_LOGICAL, 8'h81, 3'h0, 8'h40, 8'h19);
    shf(OP_ROTATE_LEFT_CARRY, 8'h81, 3'h0, 8'h03, 8'h19);
    shf(OP_ROTATE_RIGHT_CARRY, 8'h81, 3'h0, 8'hc0, 8'h15);
    shf(OP_SHIFT_RIGHT_ARITH, 8'h81, 3'h0, 8'hc0, 8'h15);
    shf(OP_NIBBLE_SWAP, 8'h81, 3'h0, 8'h18, 8'h15);
    run(OP_BIT_TO_TRANSFER_FLAG, 8'h81, 8'h00, 3'h7, 12'h000, 1'b0, 1,
      10'h001, 8'h55, 9'h000);
    shf(OP_TRANSFER_FLAG_TO_BIT, 8'h00, 3'h5, 8'h20, 8'h55);
    run(OP_BIT_TO_TRANSFER_FLAG, 8'h81, 8'h00, 3'h1, 12'h000, 1'b0, 1,
      10'h001, 8'h15, 9'h000);
    shf(OP_TRANSFER_FLAG_TO_BIT, 8'hff, 3'h2, 8'hfb, 8'h15);
    $display("shift test done");
    io_rd_data = 8'h00;
    run(OP_IO_BIT_SET_OP, 8'h00, 8'h00, 3'h3, 12'h000, 1'b0, 2, 10'h001,
      8'h15, P_IO);
    chk("io set", io_wdata_q, 8'h08);
    io_rd_data = 8'hff;
    run(OP_IO_BIT_CLEAR_OP, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 2, 10'h001,
      8'h15, P_IO);
    chk("io clear", io_wdata_q, 8'hfe);
    $display("io bit test done");
    io_rd_data = 8'h5a;
    run(OP_NOP, 0, 0, 0, 0, 0, 1, 10'h001, 8'h15, 9'h000);
    run(OP_SLEEP, 0, 0, 0, 0, 0, 1, 10'h001, 8'h15, P_SL);
    run(OP_WATCHDOG_RESTART, 0, 0, 0, 0, 0, 1, 10'h001, 8'h15,
      P_WD);
    run(OP_RELATIVE_JUMP, 0, 0, 0, 12'h020, 0, 2, 10'h021, 8'h15,
      9'h000);
    pc_s = pc_q;
    run(OP_RELATIVE_CALL, 0, 0, 0, 12'hff0, 0, 3, 10'h3f1, 8'h15,
      P_PU);
    chk("push pc", push_pc_q, 10'(pc_s + 10'h001));
    run(OP_RETURN, 0, 0, 0, 0, 0, 4, stack_pc - pc_q, 8'h15,
      P_PO);
    run(OP_INTERRUPT_RETURN, 0, 0, 0, 0, 0, 4, stack_pc - pc_q, 8'h95,
      P_PO);
    run(OP_LOAD_INDIRECT, 0, 0, 0, 0, 0, 2, 10'h001, 8'h95, P_MR);
    run(OP_STORE_INDIRECT, 0, 0, 0, 0, 0, 2, 10'h001, 8'h95, P_MW);
    run(OP_PROGRAM_MEMORY_LOAD, 0, 0, 0, 0, 0, 3, 10'h001, 8'h95,
      P_PM);
    run(OP_MOVE, 8'h11, 8'h22, 0, 0, 0, 1, 10'h001, 8'h95, P_RD);
    chk("move", rd_wdata_q, 8'h22);
    run(OP_LOAD_IMMEDIATE, 0, 8'h33, 0, 0, 0, 1, 10'h001, 8'h95,
      P_RD);
    chk("load imm", rd_wdata_q, 8'h33);
    run(OP_IO_IN, 0, 0, 0, 0, 0, 1, 10'h001, 8'h95, P_RD);
    chk("io in", rd_wdata_q, 8'h5a);
    run(OP_IO_OUT, 8'h44, 0, 0, 0, 0, 1, 10'h001, 8'h95, P_IO);
    chk("io out", io_wdata_q, 8'h44);
    instr_valid = 1'b0;
    $display("flow test done");
    summarize();
  end
endmodule : cbbie_core_tb

bind cbbie_core cbbie_core_props #(.PC_W(PC_W), .OFS_W(OFS_W)) props_u (
  .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_op(instr_op), .opd_a(opd_a), .bit_sel(bit_sel),
  .flag_sel(flag_sel), .ofs_k(ofs_k), .next_two_word(next_two_word),
  .instr_ready(instr_ready), .io_rd_data(io_rd_data), .stack_pc(stack_pc),
  .pc_q(pc_q), .status_q(status_q), .rd_we_q(rd_we_q),
  .rd_wdata_q(rd_wdata_q), .io_we_q(io_we_q), .io_wdata_q(io_wdata_q),
  .push_q(push_q), .push_pc_q(push_pc_q), .pop_q(pop_q),
  .sleep_q(sleep_q));

// ### pkg/cbbie_pkg.sv
// Constants and types of the branch, bit and shift execution unit
package cbbie_pkg;

  // ****************************************************************
  // Status bit positions and reset values
  // ****************************************************************
  localparam logic [2:0] SB_C = 3'h0;
  localparam logic [2:0] SB_Z = 3'h1;
  localparam logic [2:0] SB_N = 3'h2;
  localparam logic [2:0] SB_V = 3'h3;
  localparam logic [2:0] SB_S = 3'h4;
  localparam logic [2:0] SB_H = 3'h5;
  localparam logic [2:0] SB_T = 3'h6;
  localparam logic [2:0] SB_I = 3'h7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] NIB_HI_MSB = 3'h7;
  localparam logic [2:0] NIB_LO_MSB = 3'h3;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [5:0] {
    OP_NOP, OP_SLEEP, OP_WATCHDOG_RESTART,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
    OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_LOWER, OP_BRANCH_SAME_HIGHER,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_SET, OP_BRANCH_HALF_CLEAR,
    OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR,
    OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR,
    OP_BRANCH_INT_SET, OP_BRANCH_INT_CLEAR,
    OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP,
    OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH, OP_NIBBLE_SWAP,
    OP_FLAG_SET, OP_FLAG_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_RELATIVE_JUMP, OP_RELATIVE_CALL,
    OP_RETURN, OP_INTERRUPT_RETURN,
    OP_LOAD_INDIRECT, OP_STORE_INDIRECT, OP_PROGRAM_MEMORY_LOAD,
    OP_MOVE, OP_LOAD_IMMEDIATE, OP_IO_IN, OP_IO_OUT
  } cbbie_op_t;

endpackage : cbbie_pkg
